// ### rtl/tmr2_pkg.sv
package tmr2_pkg;
	// register offsets (byte addresses on the wishbone bus)
	localparam logic [7:0] TMR2_CTRL_ADDR = 8'hc8;
	localparam logic [7:0] TMR2_CAPL_ADDR = 8'hca;
	localparam logic [7:0] TMR2_CAPH_ADDR = 8'hcb;
	localparam logic [7:0] TMR2_CNTL_ADDR = 8'hcc;
	localparam logic [7:0] TMR2_CNTH_ADDR = 8'hcd;
	localparam logic [7:0] TMR2_CKDIV_ADDR = 8'h8e;
	localparam logic [7:0] TMR2_CTRL_RESET = 8'h00;
	localparam logic [7:0] TMR2_BYTE_RESET = 8'h00;
	// control bit positions
	localparam int TMR2_BIT_OVF = 7;
	localparam int TMR2_BIT_EXF = 6;
	localparam int TMR2_BIT_RCLK = 5;
	localparam int TMR2_BIT_TX_BAUD_SOURCE_SELECT = 4;
	localparam int TMR2_BIT_EXEN = 3;
	localparam int TMR2_BIT_RUN = 2;
	localparam int TMR2_BIT_CT = 1;
	localparam int TMR2_BIT_CPRL = 0;
	localparam int TMR2_BIT_PRESC = 5;
	// prescale divisors
	localparam int TMR2_DIV_SLOW = 12;
	localparam int TMR2_DIV_BAUD = 2;
	localparam int TMR2_DIV_W = 4;
	localparam int TMR2_BAUD_DIV = 16;

	typedef struct packed {
		logic overflow_flag;
		logic external_event_flag;
		logic rx_baud_source_select;
		logic tx_baud_source_select;
		logic ext_trigger_enable;
		logic run_control;
		logic count_source_select;
		logic capture_reload_select;
	} tmr2_ctrl_t;

	typedef struct packed {
		logic [7:0] adr;
		logic we;
		logic stb;
		logic [7:0] dat;
	} tmr2_wreq_t;
endpackage : tmr2_pkg

// ### rtl/tmr2_edge_sync.sv
`timescale 1ns/100ps
`default_nettype none
// three-stage synchroniser; a level is accepted once stages two and three agree
module tmr2_edge_sync (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pin_i,
	output logic fall_o
);
	typedef struct packed {
		logic [2:0] sync;
		logic level;
		logic fall;
	} tmr2_sync_state_t;

	tmr2_sync_state_t st_q, st_d;

	always_comb begin
		st_d = st_q;
		st_d.sync = {st_q.sync[1:0], pin_i};
		st_d.fall = 1'b0;
		if (st_q.sync[2] == st_q.sync[1]) begin
			// falling edge: filtered level was high, agreed sample now low
			st_d.fall = st_q.level & ~st_q.sync[1];
			st_d.level = st_q.sync[1];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '{sync: 3'b111, level: 1'b1, fall: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	assign fall_o = st_q.fall;
endmodule // tmr2_edge_sync
`default_nettype wire

// ### rtl/tmr2_timer.sv
// Local design decision: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - in capture mode a trigger falling edge copies the count into capture bytes
// - count from system clock divided by one or twelve, or count pin falls
// - outside baud mode, rollover from all ones sets overflow flag and interrupt
// - capture mode needs capture select and no baud select; run and trigger enable gate captures
// - auto-reload mode loads the capture bytes into the counter on overflow
// - capture select low selects auto-reload; run bit starts the counter
// - in auto-reload with trigger enable, a trigger fall reloads the counter
// - trigger capture or reload sets external flag; only software clears it
// - overflow flag never cleared by hardware; request stays while set
// - either baud source select forces baud mode with auto-reload behaviour
// - baud mode overflow reloads, sets no flag, and ticks the uart clock
// - receive baud select picks timer one or this timer for uart receive
// - transmit baud select picks timer one or this timer for uart transmit
// - uart bit rate equals this timer's overflow rate divided by sixteen
// - baud mode counts system clock over two or count pin falls
// - baud mode trigger fall sets external flag, no capture, no reload
// - run bit low holds the counter in every mode
// - prescale bit low gives clock over twelve, high undivided; else ignored
// - capture bytes are software readable and writable
module tmr2_timer import tmr2_pkg::*; #(
	parameter int CNT_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic count_input_pin_i,
	input wire logic ext_trigger_pin_i,
	input wire logic t1_overflow_i,
	output logic irq_o,
	output logic tx_baud_tick_o,
	output logic rx_baud_tick_o,
	output logic overflow_tick_o
);
	if (CNT_W != 16) begin : g_bad_width
		$error("tmr2_timer: counter must be 16 bits wide");
	end

	localparam logic [CNT_W-1:0] CNT_MAX = '1;
	localparam logic [TMR2_DIV_W-1:0] DIV_SLOW_LAST = TMR2_DIV_W'(TMR2_DIV_SLOW - 1);
	localparam logic [TMR2_DIV_W-1:0] DIV_BAUD_LAST = TMR2_DIV_W'(TMR2_DIV_BAUD - 1);
	localparam logic [3:0] BAUD_LAST = 4'(TMR2_BAUD_DIV - 1);

	typedef struct packed {
		tmr2_ctrl_t ctrl;
		logic prescale_select;
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] capture;
		logic [TMR2_DIV_W-1:0] div;
		logic [3:0] tx_div;
		logic [3:0] rx_div;
		logic ack;
		logic [31:0] rdat;
		logic irq;
		logic tx_tick;
		logic rx_tick;
		logic ovf_tick;
	} tmr2_state_t;

	tmr2_state_t st_q, st_d;
	logic count_fall, trig_fall;

	tmr2_edge_sync u_count_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(count_input_pin_i),
		.fall_o(count_fall)
	);

	tmr2_edge_sync u_trig_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(ext_trigger_pin_i),
		.fall_o(trig_fall)
	);

	// byte lane that carries a given byte address
	function automatic logic [7:0] lane_of(input logic [31:0] d, input logic [1:0] a);
		lane_of = d[8*a +: 8];
	endfunction

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] reg_adr,
			input logic [3:0] sel);
		hit = (adr[7:2] == reg_adr[7:2]) && sel[reg_adr[1:0]];
	endfunction

	logic baud_mode, capture_mode, tick, ovf, trig_ev, bus_req, bus_wr;
	logic [7:0] wr_byte;
	logic [1:0] lane;
	logic [31:0] rd;

	always_comb begin
		st_d = st_q;
		baud_mode = st_q.ctrl.rx_baud_source_select | st_q.ctrl.tx_baud_source_select;
		capture_mode = st_q.ctrl.capture_reload_select & ~baud_mode;
		trig_ev = trig_fall & st_q.ctrl.ext_trigger_enable;
		tick = 1'b0;
		st_d.tx_tick = 1'b0;
		st_d.rx_tick = 1'b0;
		st_d.ovf_tick = 1'b0;

		// time base selection
		if (st_q.ctrl.count_source_select) begin
			tick = count_fall;
			st_d.div = '0;
		end else if (baud_mode) begin
			tick = (st_q.div >= DIV_BAUD_LAST);
			st_d.div = tick ? '0 : st_q.div + 1'b1;
		end else if (st_q.prescale_select) begin
			tick = 1'b1;
			st_d.div = '0;
		end else begin
			tick = (st_q.div >= DIV_SLOW_LAST);
			st_d.div = tick ? '0 : st_q.div + 1'b1;
		end
		if (!st_q.ctrl.run_control) begin
			tick = 1'b0;
			st_d.div = '0;
		end

		ovf = tick && (st_q.count == CNT_MAX);
		if (tick) begin
			st_d.count = st_q.count + 1'b1;
		end
		if (ovf && !capture_mode) begin
			st_d.count = st_q.capture;
		end
		if (ovf && !baud_mode) begin
			st_d.ctrl.overflow_flag = 1'b1;
			st_d.ovf_tick = 1'b1;
		end

		// trigger pin events
		if (trig_ev && st_q.ctrl.run_control) begin
			if (capture_mode) begin
				st_d.capture = st_q.count;
			end else if (!baud_mode) begin
				st_d.count = st_q.capture;
			end
		end

		// baud ticks: sixteen overflows per uart bit; each divider counts only its own source,
		// otherwise the side still fed by timer one would be disturbed by our overflows
		if (ovf && baud_mode && st_q.ctrl.tx_baud_source_select) begin
			st_d.tx_div = st_q.tx_div + 1'b1;
			st_d.tx_tick = (st_q.tx_div == BAUD_LAST);
		end
		if (ovf && baud_mode && st_q.ctrl.rx_baud_source_select) begin
			st_d.rx_div = st_q.rx_div + 1'b1;
			st_d.rx_tick = (st_q.rx_div == BAUD_LAST);
		end
		if (t1_overflow_i) begin
			if (!st_q.ctrl.tx_baud_source_select) begin
				st_d.tx_div = st_q.tx_div + 1'b1;
				st_d.tx_tick = (st_q.tx_div == BAUD_LAST);
			end
			if (!st_q.ctrl.rx_baud_source_select) begin
				st_d.rx_div = st_q.rx_div + 1'b1;
				st_d.rx_tick = (st_q.rx_div == BAUD_LAST);
			end
		end

		// wishbone slave, one wait state; writes take effect with the ack
		bus_req = wb_cyc_i && wb_stb_i && !st_q.ack;
		bus_wr = bus_req && wb_we_i;
		st_d.ack = bus_req;
		lane = wb_adr_i[1:0];
		wr_byte = lane_of(wb_dat_i, lane);
		if (bus_wr && hit(wb_adr_i, TMR2_CTRL_ADDR, wb_sel_i)) begin
			wr_byte = lane_of(wb_dat_i, TMR2_CTRL_ADDR[1:0]);
			st_d.ctrl = wr_byte;
			// flags: a hardware set this cycle wins over a software clear
			st_d.ctrl.overflow_flag = wr_byte[TMR2_BIT_OVF] |
				(ovf && !baud_mode);
			st_d.ctrl.external_event_flag = wr_byte[TMR2_BIT_EXF] | trig_ev;
		end else if (trig_ev) begin
			st_d.ctrl.external_event_flag = 1'b1;
		end
		if (bus_wr && hit(wb_adr_i, TMR2_CAPL_ADDR, wb_sel_i)) begin
			st_d.capture[7:0] = lane_of(wb_dat_i, TMR2_CAPL_ADDR[1:0]);
		end
		if (bus_wr && hit(wb_adr_i, TMR2_CAPH_ADDR, wb_sel_i)) begin
			st_d.capture[15:8] = lane_of(wb_dat_i, TMR2_CAPH_ADDR[1:0]);
		end
		if (bus_wr && hit(wb_adr_i, TMR2_CNTL_ADDR, wb_sel_i)) begin
			st_d.count[7:0] = lane_of(wb_dat_i, TMR2_CNTL_ADDR[1:0]);
		end
		if (bus_wr && hit(wb_adr_i, TMR2_CNTH_ADDR, wb_sel_i)) begin
			st_d.count[15:8] = lane_of(wb_dat_i, TMR2_CNTH_ADDR[1:0]);
		end
		if (bus_wr && hit(wb_adr_i, TMR2_CKDIV_ADDR, wb_sel_i)) begin
			st_d.prescale_select = wb_dat_i[8*TMR2_CKDIV_ADDR[1:0] + TMR2_BIT_PRESC];
		end

		// read: each word holds its bytes at their lanes, unmapped reads zero
		rd = '0;
		if (wb_adr_i[7:2] == TMR2_CTRL_ADDR[7:2]) begin
			rd[8*TMR2_CTRL_ADDR[1:0] +: 8] = st_q.ctrl;
			rd[8*TMR2_CAPL_ADDR[1:0] +: 8] = st_q.capture[7:0];
			rd[8*TMR2_CAPH_ADDR[1:0] +: 8] = st_q.capture[15:8];
		end else if (wb_adr_i[7:2] == TMR2_CNTL_ADDR[7:2]) begin
			rd[8*TMR2_CNTL_ADDR[1:0] +: 8] = st_q.count[7:0];
			rd[8*TMR2_CNTH_ADDR[1:0] +: 8] = st_q.count[15:8];
		end else if (wb_adr_i[7:2] == TMR2_CKDIV_ADDR[7:2]) begin
			rd[8*TMR2_CKDIV_ADDR[1:0] + TMR2_BIT_PRESC] = st_q.prescale_select;
		end
		st_d.rdat = bus_req ? rd : '0;

		// level request while either flag stands
		st_d.irq = st_d.ctrl.overflow_flag | st_d.ctrl.external_event_flag;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
			st_q.ctrl <= TMR2_CTRL_RESET;
			st_q.count <= {TMR2_BYTE_RESET, TMR2_BYTE_RESET};
			st_q.capture <= {TMR2_BYTE_RESET, TMR2_BYTE_RESET};
		end else begin
			st_q <= st_d;
		end
	end

	assign wb_ack_o = st_q.ack;
	assign wb_dat_o = st_q.rdat;
	assign irq_o = st_q.irq;
	assign tx_baud_tick_o = st_q.tx_tick;
	assign rx_baud_tick_o = st_q.rx_tick;
	assign overflow_tick_o = st_q.ovf_tick;
endmodule // tmr2_timer
`default_nettype wire

// ### verification/tmr2_t1_model.sv
`timescale 1ns/100ps
`default_nettype none
// stands in for timer one: a one-cycle overflow pulse every PERIOD clocks
module tmr2_t1_model #(
	parameter int PERIOD = 10
) (
	input wire logic clk_i,
	input wire logic rst_i,
	output logic t1_overflow_o
);
	logic [7:0] cnt_q;
	always_ff @(posedge clk_i) begin
		if (rst_i || cnt_q == 8'(PERIOD - 1))
			cnt_q <= '0;
		else
			cnt_q <= cnt_q + 8'h01;
		t1_overflow_o <= !rst_i && cnt_q == 8'(PERIOD - 1);
	end
endmodule // tmr2_t1_model
`default_nettype wire

// ### verification/tmr2_timer_checker.sv
`timescale 1ns/100ps
`default_nettype none
module tmr2_timer_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq_o,
	input wire logic tx_baud_tick_o,
	input wire logic rx_baud_tick_o,
	input wire logic overflow_tick_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_irq_up;
		##[0:2] irq_o;
	endsequence
	property p_ack_after; s_take |=> wb_ack_o; endproperty
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_ack_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
	property p_dat_idle; !wb_ack_o |-> wb_dat_o == '0; endproperty
	property p_quiet;
		$past(rst_i) |-> !(irq_o || wb_ack_o || tx_baud_tick_o || rx_baud_tick_o || overflow_tick_o);
	endproperty
	property p_ovf_irq; overflow_tick_o |-> s_irq_up; endproperty
	// only a software write may drop the request
	property p_sw_clear;
		$fell(irq_o) |-> $past(wb_cyc_i && wb_we_i) || $past(wb_cyc_i && wb_we_i, 2);
	endproperty
	property p_tx_gap; tx_baud_tick_o |=> !tx_baud_tick_o [*8]; endproperty
	property p_rx_gap; rx_baud_tick_o |=> !rx_baud_tick_o [*8]; endproperty
	a_ack_after: assert property (p_ack_after) else $error("ack missing");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	a_ack_src: assert property (p_ack_src) else $error("ack without request");
	a_dat_idle: assert property (p_dat_idle) else $error("read data not zero");
	a_quiet: assert property (p_quiet) else $error("output active after reset");
	a_ovf_irq: assert property (p_ovf_irq) else $error("overflow without irq");
	a_sw_clear: assert property (p_sw_clear) else $error("irq dropped by itself");
	a_tx_gap: assert property (p_tx_gap) else $error("tx ticks too close");
	a_rx_gap: assert property (p_rx_gap) else $error("rx ticks too close");
endmodule // tmr2_timer_checker
bind tmr2_timer tmr2_timer_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.irq_o(irq_o), .tx_baud_tick_o(tx_baud_tick_o), .rx_baud_tick_o(rx_baud_tick_o),
	.overflow_tick_o(overflow_tick_o));
`default_nettype wire

// ### verification/tmr2_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tmr2_timer_tb import tmr2_pkg::*;;
	typedef struct packed {logic [7:0] a; logic [3:0] s; logic [31:0] d, m, e;} tmr2_row_t;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, cnt_pin = 1, trg_pin = 1;
	logic [7:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] dw = '0, q, c, v, dat_o;
	logic ack, irq, txt, rxt, ovt, t1;
	int failures = 0, num_checks = 0, cyc_n = 0, ovf_n = 0, n;
	// first two rows are reset values: sel 0 writes nothing
	tmr2_row_t rows [6] = '{
		'{TMR2_CTRL_ADDR, 4'h0, '0, '1, '0},
		'{TMR2_CNTL_ADDR, 4'h0, '0, '1, '0},
		'{TMR2_CTRL_ADDR, 4'hc, 32'h3412_0000, 32'hffff_00ff, 32'h3412_0000},
		'{TMR2_CNTL_ADDR, 4'h3, 32'hfffe, 32'hffff, 32'hfffe},
		'{8'h8c, 4'h4, 32'h0020_0000, 32'h00ff_0000, 32'h0020_0000},
		'{8'h40, 4'hf, '1, '1, '0}};
	tmr2_t1_model #(.PERIOD(10)) u_t1 (.clk_i(clk_i), .rst_i(rst_i), .t1_overflow_o(t1));
	tmr2_timer u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.count_input_pin_i(cnt_pin), .ext_trigger_pin_i(trg_pin), .t1_overflow_i(t1),
		.irq_o(irq), .tx_baud_tick_o(txt), .rx_baud_tick_o(rxt), .overflow_tick_o(ovt));
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc_n++;
		ovf_n += ovt;
		if (cyc_n == 20000) begin
			failures++;
			report_and_stop();
		end
	end
	task report_and_stop();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task bus(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d, input logic w);
		@(posedge clk_i);
		{cyc, stb, adr, sel, dw, we} <= {2'b11, a, s, d, w};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = dat_o;
		{cyc, stb, we} <= 3'b000;
	endtask
	// low and high phases kept well above the synchroniser's minimum
	task pulse(input logic t);
		if (t)
			trg_pin <= 1'b0;
		else
			cnt_pin <= 1'b0;
		repeat (4) @(posedge clk_i);
		{trg_pin, cnt_pin} <= 2'b11;
		repeat (8) @(posedge clk_i);
	endtask
	task tick(input logic r);
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while ((r ? rxt : txt) !== 1'b1);
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			bus(rows[i].a, rows[i].s, rows[i].d, 1'b1);
			bus(rows[i].a, 4'hf, '0, 1'b0);
			chk("register", q & rows[i].m, rows[i].e);
		end
		bus(TMR2_CTRL_ADDR, 4'h1, 32'h04, 1'b1);
		while (ovf_n == 0) @(posedge clk_i);
		bus(TMR2_CTRL_ADDR, 4'hf, '0, 1'b0);
		chk("overflow flag", q & 32'hffff_00ff, 32'h3412_0084);
		chk("irq set", irq, 1);
		bus(TMR2_CNTL_ADDR, 4'hf, '0, 1'b0);
		chk("reload", q[15:8], 8'h34);
		bus(TMR2_CTRL_ADDR, 4'h1, '0, 1'b1);
		repeat (3) @(posedge clk_i);
		chk("irq clear", irq, 0);
		bus(TMR2_CNTL_ADDR, 4'hf, '0, 1'b0);
		v = q;
		bus(TMR2_CNTL_ADDR, 4'hf, '0, 1'b0);
		chk("held count", q, v);
		bus(TMR2_CTRL_ADDR, 4'h1, 32'h0d, 1'b1);
		pulse(1'b1);
		bus(TMR2_CTRL_ADDR, 4'hf, '0, 1'b0);
		c = q;
		bus(TMR2_CNTL_ADDR, 4'hf, '0, 1'b0);
		chk("capture", {c[7:0], c[31:16] != 16'h3412, q[15:0] - c[31:16] < 16'd40}, 10'h137);
		bus(TMR2_CTRL_ADDR, 4'h1, 32'h05, 1'b1);
		pulse(1'b1);
		bus(TMR2_CTRL_ADDR, 4'hf, '0, 1'b0);
		chk("no capture", q & 32'hffff_00ff, c & 32'hffff_0000 | 32'h05);
		bus(TMR2_CTRL_ADDR, 4'h1, 32'h06, 1'b1);
		bus(TMR2_CNTL_ADDR, 4'h3, '0, 1'b1);
		repeat (3) pulse(1'b0);
		bus(TMR2_CNTL_ADDR, 4'hf, '0, 1'b0);
		chk("pin count", q[15:0], 16'h0003);
		bus(TMR2_CTRL_ADDR, 4'hc, 32'hfff0_0000, 1'b1);
		bus(TMR2_CNTL_ADDR, 4'h3, 32'hfff0, 1'b1);
		bus(TMR2_CTRL_ADDR, 4'h1, 32'h2c, 1'b1);
		v = ovf_n;
		tick(1'b0);
		tick(1'b0);
		chk("tx period", n, 160);
		tick(1'b1);
		tick(1'b1);
		chk("rx period", n, 512);
		pulse(1'b1);
		bus(TMR2_CTRL_ADDR, 4'hf, '0, 1'b0);
		chk("baud trigger", q & 32'hffff_00ff, 32'hfff0_006c);
		chk("no overflow", ovf_n, v);
		report_and_stop();
	end
endmodule // tmr2_timer_tb
`default_nettype wire
